// file: rtl/pct_pkg.sv
// constants and types shared by the prescaled compare timer
package pct_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] PCT_CTL_OFS = 8'h00;
  localparam logic [7:0] PCT_PSC_OFS = 8'h04;
  localparam logic [7:0] PCT_CMP_OFS = 8'h08;
  localparam logic [7:0] PCT_IEN_OFS = 8'h0C;
  localparam logic [7:0] PCT_STS_OFS = 8'h10;
  localparam logic [7:0] PCT_CNT_OFS = 8'h14;
  localparam logic [7:0] PCT_CAP_OFS = 8'h18;

  // ****************************************
  // control register bit positions
  // ****************************************
  localparam int PCT_CTL_RUN  = 0;
  localparam int PCT_CTL_RST  = 1;
  localparam int PCT_CTL_WAKE = 2;
  localparam int PCT_CTL_DBG  = 3;
  localparam int PCT_CTL_MODE = 4;
  localparam int PCT_CTL_ACT  = 7;
  localparam int PCT_CTL_ADC  = 8;
  localparam int PCT_CTL_DMA  = 10;
  localparam int PCT_CTL_TSEL = 11;
  localparam int PCT_CTL_EVT  = 12;
  localparam int PCT_CTL_CAPE = 16;

  // ****************************************
  // status and enable bit positions
  // ****************************************
  localparam int PCT_STS_TO  = 0;
  localparam int PCT_STS_CAP = 1;
  localparam int PCT_STS_WK  = 4;
  localparam int PCT_STS_OVR = 5;
  localparam int PCT_STS_FE  = 6;
  localparam int PCT_IEN_TO  = 0;
  localparam int PCT_IEN_CAP = 1;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [31:0] PCT_REG_RST  = 32'h00000000;
  localparam int          PCT_RST_CYC  = 3;
  localparam logic [1:0]  PCT_RST_LAST = 2'(PCT_RST_CYC - 1);

  typedef enum logic [1:0] {
    PCT_ONE_SHOT,
    PCT_PERIODIC,
    PCT_TOGGLE,
    PCT_CONTINUOUS
  } pct_mode_e;

  // software control fields
  typedef struct packed {
    logic      cap_en;
    logic      evt_en;
    logic      tsel;
    logic      dma_en;
    logic      adc_en;
    pct_mode_e mode;
    logic      dbg_ign;
    logic      wake_en;
  } pct_ctl_s;

endpackage

// file: rtl/pct_timer.sv
// 24-bit prescaled compare timer channel with axi4-lite registers
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps

module pct_timer
  import pct_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        count_pin,
  input  wire logic        capture_pin,
  input  wire logic        debug_halt,
  output logic             irq,
  output logic             wake_req,
  output logic             adc_trig,
  output logic             dma_trig,
  output logic             toggle_out
);
  import pct_pkg::*;

  // ****************************************
  // state
  // ****************************************
  pct_ctl_s    ctl;
  logic        count_run;
  logic        rst_busy;
  logic [1:0]  rst_cnt;
  logic [7:0]  prescale_value;
  logic [23:0] compare_value;
  logic [1:0]  irq_en;
  logic        timeout_flag;
  logic        capture_flag;
  logic        wake_flag;
  logic        capture_overrun_flag;
  logic        capture_falling_flag;
  logic [7:0]  psc_cnt;
  logic [23:0] count_value;
  logic [23:0] cap_data;
  logic [2:0]  cnt_sync;
  logic [2:0]  cap_sync;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // ****************************************
  // bus write decode
  // ****************************************
  logic        wr_go;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic        wr_ctl;
  logic        wr_psc;
  logic        wr_cmp;
  logic        wr_ien;
  logic        wr_sts;
  logic        wr_cnt;
  logic        wr_ok;
  logic [31:0] ctl_word;
  logic [31:0] next_ctl;
  logic [7:0]  next_psc;
  logic [23:0] next_cmp;

  assign wr_go  = aw_held && w_held && !s_axi_bvalid;
  assign wmask  = {{8{w_strb[3]}}, {8{w_strb[2]}},
                   {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign wbits  = w_data & wmask;
  assign wr_ctl = wr_go && (aw_addr == PCT_CTL_OFS);
  assign wr_psc = wr_go && (aw_addr == PCT_PSC_OFS);
  assign wr_cmp = wr_go && (aw_addr == PCT_CMP_OFS);
  assign wr_ien = wr_go && (aw_addr == PCT_IEN_OFS);
  assign wr_sts = wr_go && (aw_addr == PCT_STS_OFS);
  assign wr_cnt = wr_go && (aw_addr == PCT_CNT_OFS);
  assign wr_ok  = wr_ctl || wr_psc || wr_cmp || wr_ien || wr_sts
                  || wr_cnt || (aw_addr == PCT_CAP_OFS);

  // byte lanes merge into the current contents
  assign next_ctl = (ctl_word & ~wmask) | wbits;
  assign next_psc = (prescale_value & ~wmask[7:0]) | wbits[7:0];
  assign next_cmp = (compare_value & ~wmask[23:0]) | wbits[23:0];

  // ****************************************
  // pin synchronisers
  // ****************************************
  // third stage only feeds the edge detect, never the first stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_sync <= 3'h0;
      cap_sync <= 3'h0;
    end
    else if (clk_en)
    begin
      cnt_sync <= {cnt_sync[1:0], count_pin};
      cap_sync <= {cap_sync[1:0], capture_pin};
    end
  end

  logic cnt_rise;
  logic cap_rise;
  logic cap_fall;
  logic cap_evt;
  logic dbg_halt_q;
  logic dbg_halt_s;

  assign cnt_rise = cnt_sync[1] && !cnt_sync[2];
  assign cap_rise = cap_sync[1] && !cap_sync[2];
  assign cap_fall = !cap_sync[1] && cap_sync[2];
  assign cap_evt  = ctl.cap_en && (cap_rise || cap_fall);

  // debug halt comes from another block's domain too
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dbg_halt_q <= 1'b0;
      dbg_halt_s <= 1'b0;
    end
    else if (clk_en)
    begin
      dbg_halt_q <= debug_halt;
      dbg_halt_s <= dbg_halt_q;
    end
  end

  // ****************************************
  // counting engine
  // ****************************************
  logic        frozen;
  logic        tick;
  logic        adv;
  logic [23:0] cnt_inc;
  logic        match;
  logic        restart;

  assign frozen  = dbg_halt_s && !ctl.dbg_ign;
  assign tick    = count_run && !rst_busy && !frozen
                   && (!ctl.evt_en || cnt_rise);
  assign adv     = tick && (psc_cnt == prescale_value);
  assign cnt_inc = count_value + 24'h000001;
  assign match   = adv && (cnt_inc == compare_value);
  assign restart = (wr_psc && (next_psc != prescale_value))
                   || (wr_cmp && ctl.mode != PCT_CONTINUOUS);

  // prescaler and up counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      psc_cnt     <= 8'h00;
      count_value <= 24'h000000;
    end
    else if (clk_en)
    begin
      if (rst_busy || wr_cnt || restart || (wr_ctl
          && next_ctl[PCT_CTL_RST]))
      begin
        psc_cnt     <= 8'h00;
        count_value <= 24'h000000;
      end
      else if (adv)
      begin
        psc_cnt <= 8'h00;
        // periodic, toggle and one-shot fold back on a match
        if (match && ctl.mode != PCT_CONTINUOUS)
          count_value <= 24'h000000;
        else
          count_value <= cnt_inc;
      end
      else if (tick)
        psc_cnt <= psc_cnt + 8'h01;
    end
  end

  // toggle pin inverts on each match in toggle mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      toggle_out <= 1'b0;
    else if (clk_en && match && ctl.mode == PCT_TOGGLE)
      toggle_out <= !toggle_out;
  end

  // ****************************************
  // control register
  // ****************************************
  assign ctl_word = {15'h0, ctl.cap_en, 3'h0, ctl.evt_en, ctl.tsel,
                     ctl.dma_en, 1'b0, ctl.adc_en, count_run, 1'b0,
                     ctl.mode, ctl.dbg_ign, ctl.wake_en, rst_busy,
                     count_run};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctl <= pct_ctl_s'(PCT_REG_RST[8:0]);
    else if (clk_en && wr_ctl)
    begin
      ctl.cap_en  <= next_ctl[PCT_CTL_CAPE];
      ctl.evt_en  <= next_ctl[PCT_CTL_EVT];
      ctl.tsel    <= next_ctl[PCT_CTL_TSEL];
      ctl.dma_en  <= next_ctl[PCT_CTL_DMA];
      ctl.adc_en  <= next_ctl[PCT_CTL_ADC];
      ctl.mode    <= pct_mode_e'(next_ctl[PCT_CTL_MODE +: 2]);
      ctl.dbg_ign <= next_ctl[PCT_CTL_DBG];
      ctl.wake_en <= next_ctl[PCT_CTL_WAKE];
    end
  end

  // run bit: a reset request in the same write wins over a start
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_run <= PCT_REG_RST[PCT_CTL_RUN];
    else if (clk_en)
    begin
      if (wr_ctl && next_ctl[PCT_CTL_RST])
        count_run <= 1'b0;
      else if (wr_ctl)
        count_run <= next_ctl[PCT_CTL_RUN];
      else if (match && ctl.mode == PCT_ONE_SHOT)
        count_run <= 1'b0;
    end
  end

  // reset request stays visible for a fixed number of cycles
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rst_busy <= 1'b0;
      rst_cnt  <= 2'h0;
    end
    else if (clk_en)
    begin
      if (wr_ctl && next_ctl[PCT_CTL_RST])
      begin
        rst_busy <= 1'b1;
        rst_cnt  <= 2'h0;
      end
      else if (rst_busy)
      begin
        rst_cnt  <= rst_cnt + 2'h1;
        rst_busy <= (rst_cnt != PCT_RST_LAST);
      end
    end
  end

  // ****************************************
  // prescale, compare and enable registers
  // ****************************************
  // compare 0 or 1 is left to software to avoid
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prescale_value <= PCT_REG_RST[7:0];
      compare_value  <= PCT_REG_RST[23:0];
      irq_en         <= PCT_REG_RST[1:0];
    end
    else if (clk_en)
    begin
      if (wr_psc)
        prescale_value <= next_psc;
      if (wr_cmp)
        compare_value <= next_cmp;
      if (wr_ien)
        irq_en <= (irq_en & ~wmask[1:0]) | wbits[1:0];
    end
  end

  // ****************************************
  // status flags and capture
  // ****************************************
  logic [6:0] clr;
  logic       wake_now;

  assign clr      = wr_sts ? wbits[6:0] : 7'h00;
  assign wake_now = ctl.wake_en && (timeout_flag || capture_flag);

  // hardware set beats a write-one clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timeout_flag         <= 1'b0;
      capture_flag         <= 1'b0;
      wake_flag            <= 1'b0;
      capture_overrun_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      timeout_flag <= match || (timeout_flag && !clr[PCT_STS_TO]);
      capture_flag <= cap_evt
                      || (capture_flag && !clr[PCT_STS_CAP]);
      wake_flag    <= (wake_now && !wake_req)
                      || (wake_flag && !clr[PCT_STS_WK]);
      capture_overrun_flag <= (cap_evt && capture_flag)
                      || (capture_overrun_flag && !clr[PCT_STS_OVR]);
    end
  end

  // data and edge polarity only load when the flag is clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cap_data             <= 24'h000000;
      capture_falling_flag <= 1'b0;
    end
    else if (clk_en && cap_evt && !capture_flag)
    begin
      cap_data             <= count_value;
      capture_falling_flag <= cap_fall;
    end
  end

  // ****************************************
  // outputs to the system
  // ****************************************
  logic sel_evt;

  assign sel_evt = ctl.tsel ? (cap_evt && !capture_flag) : match;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq      <= 1'b0;
      wake_req <= 1'b0;
      adc_trig <= 1'b0;
      dma_trig <= 1'b0;
    end
    else if (clk_en)
    begin
      irq      <= (timeout_flag && irq_en[PCT_IEN_TO])
                  || (capture_flag && irq_en[PCT_IEN_CAP]);
      wake_req <= wake_now;
      adc_trig <= sel_evt && ctl.adc_en;
      dma_trig <= sel_evt && ctl.dma_en;
    end
  end

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;

  // address and data are taken in either order, then answered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [31:0] sts_word;

  assign sts_word = {25'h0, capture_falling_flag, capture_overrun_flag,
                     wake_flag, 2'b00, capture_flag, timeout_flag};
  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    rd_ok   = 1'b1;
    rd_word = 32'h00000000;
    unique case ({s_axi_araddr[7:2], 2'b00})
      PCT_CTL_OFS: rd_word = ctl_word;
      PCT_PSC_OFS: rd_word = {24'h0, prescale_value};
      PCT_CMP_OFS: rd_word = {8'h0, compare_value};
      PCT_IEN_OFS: rd_word = {30'h0, irq_en};
      PCT_STS_OFS: rd_word = sts_word;
      PCT_CNT_OFS: rd_word = {rst_busy, 7'h0, count_value};
      PCT_CAP_OFS: rd_word = {8'h0, cap_data};
      default:     rd_ok   = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && !s_axi_rvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// file: verif/pct_timer_checker.sv
// bus handshake and trigger pulse checks for the compare timer
`timescale 1ns/1ps

// ****************************************
// checker module
// ****************************************
module pct_timer_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        adc_trig,
  input wire logic        dma_trig
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // address and data taken at the same edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // a read answer not yet accepted by the master
  sequence s_r_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence

  property p_wr_answer;
    s_wr_taken |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("no write answer");

  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");

  property p_b_code;
    s_axi_bvalid |-> s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10;
  endproperty
  a_b_code: assert property (p_b_code) else $error("bad write code");

  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("no read answer");

  property p_r_hold;
    s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer changed");

  // an error answer carries no stale data
  property p_r_err_zero;
    s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0;
  endproperty
  a_r_err_zero: assert property (p_r_err_zero) else $error("error data");

  property p_adc_pulse;
    adc_trig |=> !adc_trig;
  endproperty
  a_adc_pulse: assert property (p_adc_pulse) else $error("adc level");

  property p_dma_pulse;
    dma_trig |=> !dma_trig;
  endproperty
  a_dma_pulse: assert property (p_dma_pulse) else $error("dma level");
endmodule

bind pct_timer pct_timer_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .adc_trig(adc_trig), .dma_trig(dma_trig)
);

// file: verif/pct_timer_bench.sv
// self-checking bench for the prescaled compare timer
`timescale 1ns/1ps

module pct_timer_bench;
  import pct_pkg::*;

  // ****************************************
  // signals and constants
  // ****************************************
  logic        aclk, irq, wake, adc, dma, tgl;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        aresetn = 1'b0, clk_en = 1'b1, dbg = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        cnt_pin = 1'b0, cap_pin = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [3:0]  wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, v0, v1;
  logic [1:0]  bresp, rresp, bresp_q, rresp_q;
  int          failures = 0, comparisons = 0, cyc = 0;
  logic [7:0]  ofs [3] = '{PCT_PSC_OFS, PCT_CMP_OFS, PCT_IEN_OFS};
  logic [31:0] msk [3] = '{32'h000000FF, 32'h00FFFFFF, 32'h00000003};

  localparam logic [31:0] RUN  = 32'h1 << PCT_CTL_RUN;
  localparam logic [31:0] RST  = 32'h1 << PCT_CTL_RST;
  localparam logic [31:0] WAKE = 32'h1 << PCT_CTL_WAKE;
  localparam logic [31:0] DBGI = 32'h1 << PCT_CTL_DBG;
  localparam logic [31:0] ACT  = 32'h1 << PCT_CTL_ACT;
  localparam logic [31:0] ADC  = 32'h1 << PCT_CTL_ADC;
  localparam logic [31:0] DMA  = 32'h1 << PCT_CTL_DMA;
  localparam logic [31:0] TSEL = 32'h1 << PCT_CTL_TSEL;
  localparam logic [31:0] EVT  = 32'h1 << PCT_CTL_EVT;
  localparam logic [31:0] CAPE = 32'h1 << PCT_CTL_CAPE;
  localparam logic [31:0] PER  = 32'(PCT_PERIODIC) << PCT_CTL_MODE;
  localparam logic [31:0] TOG  = 32'(PCT_TOGGLE) << PCT_CTL_MODE;
  localparam logic [31:0] CONT = 32'(PCT_CONTINUOUS) << PCT_CTL_MODE;

  // device under test; clock enable is dropped for five edges once, and debug halt freezing is exercised
  pct_timer u_dut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .count_pin(cnt_pin), .capture_pin(cap_pin),
    .debug_halt(dbg), .irq(irq), .wake_req(wake), .adc_trig(adc),
    .dma_trig(dma), .toggle_out(tgl)
  );

  // 100 ns clock
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic final_report;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // bready stands high from the request on; a missing answer is a mismatch
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 100)
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    chk(32'(bvalid), 32'h1);
    bresp_q = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    d = 32'hDEADBEEF;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 100)
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    chk(32'(rvalid), 32'h1);
    d = rdata;
    rresp_q = rresp;
    rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  // toggle mode: cycles between two output flips, trigger pulses between
  task automatic tog(input logic [31:0] c, input int p, input int m,
                     input int ea, input int ed);
    int t, na, nd;
    logic o;
    wr(PCT_CTL_OFS, 32'h0);
    wr(PCT_PSC_OFS, 32'(p));
    wr(PCT_CMP_OFS, 32'(m));
    wr(PCT_CTL_OFS, c | RUN | TOG);
    for (int k = 0; k < 2; k++)
    begin
      o = tgl;
      t = 0;
      na = 0;
      nd = 0;
      while (tgl === o && t < 3000)
      begin
        @(posedge aclk);
        t++;
        na += int'(adc === 1'b1);
        nd += int'(dma === 1'b1);
      end
    end
    chk(32'(t), 32'((p + 1) * m));
    chk(32'(na), 32'(ea));
    chk(32'(nd), 32'(ed));
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      final_report;
    end
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, writable widths, unmapped address
    rc(PCT_CTL_OFS, PCT_REG_RST);
    rc(PCT_STS_OFS, PCT_REG_RST);
    for (int i = 0; i < 3; i++)
    begin
      rc(ofs[i], PCT_REG_RST);
      wr(ofs[i], 32'hFFFFFFFF);
      rc(ofs[i], msk[i]);
      wr(ofs[i], 32'h00000002);
    end
    wr(8'h1C, 32'h000000FF);
    chk(32'(bresp_q), 32'h2);
    rc(8'h1C, 32'h0);
    chk(32'(rresp_q), 32'h2);
    // division, period and trigger routing
    tog(ADC, 0, 3, 1, 0);
    tog(DMA, 1, 5, 0, 1);
    tog(ADC | DMA | TSEL, 2, 2, 0, 0);
    // one-shot stop, interrupt gating, wake, write-one clear
    wr(PCT_CTL_OFS, 32'h0);
    wr(PCT_IEN_OFS, 32'h0);
    wr(PCT_STS_OFS, 32'h0000007F);
    wr(PCT_CMP_OFS, 32'h4);
    wr(PCT_CTL_OFS, RUN);
    repeat (30) @(posedge aclk);
    rc(PCT_CTL_OFS, 32'h0);
    rc(PCT_STS_OFS, 32'h1);
    chk(32'({irq, wake}), 32'h0);
    wr(PCT_IEN_OFS, 32'h1);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h1);
    wr(PCT_CTL_OFS, WAKE | ACT);
    repeat (2) @(posedge aclk);
    chk(32'(wake), 32'h1);
    rc(PCT_CTL_OFS, WAKE);
    wr(PCT_STS_OFS, 32'h0);
    rc(PCT_STS_OFS, 32'h11);
    wr(PCT_STS_OFS, 32'h11);
    rc(PCT_STS_OFS, 32'h0);
    chk(32'({irq, wake}), 32'h0);
    // continuous counting: run, halt, compare write, stop and resume
    wr(PCT_PSC_OFS, 32'h0);
    wr(PCT_CMP_OFS, 32'h00FFFFFF);
    wr(PCT_CTL_OFS, RUN | CONT);
    rd(PCT_CNT_OFS, v0);
    rd(PCT_CNT_OFS, v1);
    chk(32'(v1 > v0), 32'h1);
    dbg <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(PCT_CNT_OFS, v0);
    repeat (5) @(posedge aclk);
    rd(PCT_CNT_OFS, v1);
    chk(v1, v0);
    wr(PCT_CTL_OFS, RUN | CONT | DBGI);
    rd(PCT_CNT_OFS, v0);
    rd(PCT_CNT_OFS, v1);
    chk(32'(v1 > v0), 32'h1);
    dbg <= 1'b0;
    wr(PCT_CMP_OFS, 32'h00800000);
    rd(PCT_CNT_OFS, v1);
    chk(32'(v1 > v0), 32'h1);
    wr(PCT_CTL_OFS, CONT);
    rd(PCT_CNT_OFS, v0);
    repeat (5) @(posedge aclk);
    rc(PCT_CNT_OFS, v0);
    wr(PCT_CTL_OFS, RUN | CONT);
    rd(PCT_CNT_OFS, v1);
    chk(32'(v1 > v0), 32'h1);
    // clock enable low for five edges: only three advances between reads
    rd(PCT_CNT_OFS, v0);
    clk_en <= 1'b0;
    repeat (5) @(posedge aclk);
    clk_en <= 1'b1;
    rd(PCT_CNT_OFS, v1);
    chk(v1 - v0, 32'h3);
    // compare write restarts outside continuous mode
    wr(PCT_CTL_OFS, RUN | PER);
    wr(PCT_CMP_OFS, 32'h00700000);
    rd(PCT_CNT_OFS, v1);
    chk(32'(v1 < 8), 32'h1);
    // prescale change restarts the count
    wr(PCT_CTL_OFS, RUN | CONT);
    repeat (20) @(posedge aclk);
    wr(PCT_PSC_OFS, 32'h3);
    rd(PCT_CNT_OFS, v1);
    chk(32'(v1 < 4), 32'h1);
    // reset request wins over run and clears itself
    wr(PCT_CTL_OFS, RUN | RST | CONT);
    repeat (4) @(posedge aclk);
    rc(PCT_CTL_OFS, CONT);
    rc(PCT_CNT_OFS, 32'h0);
    // event counting: only pin edges advance the count
    wr(PCT_PSC_OFS, 32'h0);
    wr(PCT_CTL_OFS, RUN | CONT | EVT);
    repeat (5)
    begin
      cnt_pin <= 1'b1;
      repeat (3) @(posedge aclk);
      cnt_pin <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    repeat (6) @(posedge aclk);
    rc(PCT_CNT_OFS, 32'h5);
    // capture, overrun and edge polarity
    wr(PCT_CTL_OFS, CAPE);
    wr(PCT_IEN_OFS, 32'h2);
    cap_pin <= 1'b1;
    repeat (6) @(posedge aclk);
    rc(PCT_STS_OFS, 32'h2);
    chk(32'(irq), 32'h1);
    wr(PCT_CTL_OFS, CAPE | RUN | CONT);
    cap_pin <= 1'b0;
    repeat (6) @(posedge aclk);
    rc(PCT_STS_OFS, 32'h22);
    rc(PCT_CAP_OFS, 32'h5);
    wr(PCT_STS_OFS, 32'h22);
    cap_pin <= 1'b1;
    repeat (6) @(posedge aclk);
    wr(PCT_STS_OFS, 32'h2);
    // capture as trigger source: one adc pulse for the accepted capture
    wr(PCT_CTL_OFS, CAPE | RUN | CONT | TSEL | ADC);
    cap_pin <= 1'b0;
    v0 = 32'h0;
    repeat (6)
    begin
      @(posedge aclk);
      v0 = v0 + 32'(adc);
    end
    chk(v0, 32'h1);
    rc(PCT_STS_OFS, 32'h42);
    wr(PCT_IEN_OFS, 32'h0);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    final_report;
  end
endmodule
